// [common/tarb_regs.svh]
`ifndef TARB_REGS_SVH
`define TARB_REGS_SVH
// Result word layout
`define TARB_FULL_BIT 15
`define TARB_EMPTY_BIT 14
`define TARB_RSVD_BIT 13
`define TARB_TAG_BIT 12
`define TARB_RES_MSB 11
`define TARB_RES_W 12
`define TARB_DEPTH 64
// Reset image of the word: full clear, empty set
`define TARB_WORD_RESET 16'h4000
// Source tag encodings
`define TARB_TAG_ZERO 1'b0
`define TARB_TAG_ONE 1'b1
`endif

// [common/tarb_pkg.sv]
package tarb_pkg;
  // Converter sources
  typedef enum logic [2:0] {
    SRC_HORIZ,
    SRC_VERT,
    SRC_PRESSURE_FIRST,
    SRC_PRESSURE_SECOND,
    SRC_BATTERY_INPUT,
    SRC_FIRST_AUXILIARY_INPUT,
    SRC_SECOND_AUXILIARY_INPUT,
    SRC_TEMPERATURE
  } tarb_src_t;
  // Scan kinds
  typedef enum logic [2:0] {
    SCAN_XY,
    SCAN_XYZ,
    SCAN_Z,
    SCAN_AUTO_AUX,
    SCAN_PORT,
    SCAN_SINGLE
  } tarb_scan_t;
endpackage

// [verilog/tarb_fifo.sv]
`timescale 1ns/10ps
`default_nettype none
module tarb_fifo #(
  parameter int WIDTH = 13,
  parameter int DEPTH = 64
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o,
  output logic full_o,
  output logic [$clog2(DEPTH):0] count_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  wire do_push = in_valid_i && in_ready_o;
  wire do_pop = out_valid_o && out_ready_i;
  assign in_ready_o = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o = mem_q[rd_q];
  assign full_o = !in_ready_o;
  assign count_o = cnt_q;
  always_ff @(posedge clk_i)
  begin
    if (ce_i && do_push)
      mem_q[wr_q] <= in_data_i;
  end
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end
    else if (ce_i)
    begin
      if (do_push)
        wr_q <= wr_q + AW'(1);
      if (do_pop)
        rd_q <= rd_q + AW'(1);
      cnt_q <= cnt_q + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end
endmodule // tarb_fifo
`default_nettype wire

// [verilog/tarb_scan_seq.sv]
`timescale 1ns/10ps
`default_nettype none
// Orders the results of one scan into the buffer
module tarb_scan_seq
  import tarb_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic start_i,
  input wire tarb_scan_t scan_i,
  input wire logic [2:0] aux_sel_i,
  input wire tarb_src_t single_src_i,
  output logic busy_o,
  output tarb_src_t want_o,
  input wire logic step_i
);
  tarb_src_t list_q [4];
  logic [2:0] len_q;
  logic [2:0] idx_q;
  tarb_src_t l [4];
  logic [2:0] n;
  always_comb
  begin
    l[0] = SRC_VERT;
    l[1] = SRC_HORIZ;
    l[2] = SRC_PRESSURE_FIRST;
    l[3] = SRC_PRESSURE_SECOND;
    n = 3'd2;
    case (scan_i)
      SCAN_XY: n = 3'd2;
      SCAN_XYZ: n = 3'd4;
      SCAN_Z:
      begin
        l[0] = SRC_PRESSURE_FIRST;
        l[1] = SRC_PRESSURE_SECOND;
      end
      SCAN_AUTO_AUX:
      begin
        n = 3'd0;
        if (aux_sel_i[0])
        begin
          l[n[1:0]] = SRC_FIRST_AUXILIARY_INPUT;
          n = n + 3'd1;
        end
        if (aux_sel_i[1])
        begin
          l[n[1:0]] = SRC_SECOND_AUXILIARY_INPUT;
          n = n + 3'd1;
        end
        if (aux_sel_i[2])
        begin
          l[n[1:0]] = SRC_TEMPERATURE;
          n = n + 3'd1;
        end
      end
      SCAN_PORT:
      begin
        l[0] = SRC_BATTERY_INPUT;
        l[1] = SRC_FIRST_AUXILIARY_INPUT;
        l[2] = SRC_SECOND_AUXILIARY_INPUT;
        n = 3'd3;
      end
      SCAN_SINGLE:
      begin
        l[0] = single_src_i;
        n = 3'd1;
      end
      default: n = 3'd0;
    endcase
  end
  assign busy_o = (idx_q != len_q);
  assign want_o = list_q[idx_q[1:0]];
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      len_q <= '0;
      idx_q <= '0;
      for (int i = 0; i < 4; i++)
        list_q[i] <= SRC_HORIZ;
    end
    else if (ce_i)
    begin
      if (!busy_o && start_i)
      begin
        list_q <= l;
        len_q <= n;
        idx_q <= '0;
      end
      else if (busy_o && step_i)
        idx_q <= idx_q + 3'd1;
    end
  end
endmodule // tarb_scan_seq
`default_nettype wire

// [verilog/tarb_result_buffer.sv]
// Functional notes
// - After reset the word reads full flag 0 and empty flag 1.
// - The word is read-only and host writes change nothing.
// - With buffer mode on, every finished result goes into the buffer unless all 64 entries are full.
// - Word layout is full 15, empty 14, reserved 13, tag 12, result 11..0.
// - Full is set one cycle after all 64 entries hold unread data, and clears in the word of any read.
// - Empty shows no unread data and is set in the word of the read taking the last entry.
// - Tag 0 marks horizontal, first pressure, battery or second auxiliary.
// - Tag 1 marks vertical, second pressure, first auxiliary or temperature.
// - A two-coordinate scan stores vertical then horizontal.
// - A full scan stores vertical, horizontal, first then second pressure; pressure-only stores first then second.
// - An auxiliary scan stores only selected inputs in order first, second auxiliary, temperature.
// - A port scan stores battery, first auxiliary, second auxiliary.
`include "tarb_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module tarb_result_buffer
  import tarb_pkg::*;
#(
  parameter int DEPTH = `TARB_DEPTH,
  parameter int RES_W = `TARB_RES_W
) (
  input wire logic CLK_I,
  input wire logic RESETN_I,
  input wire logic CE_I,
  input wire logic BUFFER_MODE_I,
  input wire logic SCAN_START_I,
  input wire tarb_scan_t SCAN_KIND_I,
  input wire logic [2:0] AUX_SELECT_I,
  input wire tarb_src_t SINGLE_SRC_I,
  input wire logic CONV_DONE_I,
  input wire logic [RES_W-1:0] CONV_RESULT_I,
  input wire logic WORD_RD_I,
  input wire logic WORD_WR_I,
  input wire logic [15:0] WORD_WDATA_I,
  output logic [15:0] WORD_RDATA_O,
  output logic SCAN_BUSY_O,
  output tarb_src_t SCAN_WANT_O,
  output logic RESULT_DROPPED_O
);
  localparam int FW = RES_W + 1;
  localparam int CW = $clog2(DEPTH) + 1;
  localparam int WORD_W = 16;
  localparam int FULL_BIT = `TARB_FULL_BIT;
  localparam int EMPTY_BIT = `TARB_EMPTY_BIT;
  localparam int RSVD_BIT = `TARB_RSVD_BIT;
  localparam int TAG_BIT = `TARB_TAG_BIT;
  localparam int RES_MSB = `TARB_RES_MSB;

  // Tag follows from the source that the scan list names for this result
  function automatic logic tag_of(input tarb_src_t s);
    case (s)
      SRC_VERT, SRC_PRESSURE_SECOND, SRC_FIRST_AUXILIARY_INPUT, SRC_TEMPERATURE:
      begin
        tag_of = `TARB_TAG_ONE;
      end
      default:
      begin
        tag_of = `TARB_TAG_ZERO;
      end
    endcase
  endfunction

  function automatic logic count_is(input logic [CW-1:0] c, input int unsigned v);
    count_is = (c == CW'(v));
  endfunction

  // Whole word from two flags and one stored entry; the reserved bit reads 0
  function automatic logic [WORD_W-1:0] make_word(
    input logic full,
    input logic empty,
    input logic [FW-1:0] entry
  );
    logic [WORD_W-1:0] w;
    w = '0;
    w[FULL_BIT] = full;
    w[EMPTY_BIT] = empty;
    w[RSVD_BIT] = 1'b0;
    w[TAG_BIT] = entry[FW-1];
    w[RES_MSB:0] = entry[RES_W-1:0];
    make_word = w;
  endfunction

  wire seq_busy;
  tarb_src_t seq_want;

  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [FW-1:0] fifo_out_data;
  wire [CW-1:0] fifo_count;

  // Scan order: each finished result takes the next source in the list
  wire step = CONV_DONE_I && seq_busy;
  wire push_req = step && BUFFER_MODE_I;
  wire push_tag = tag_of(seq_want);
  wire [FW-1:0] push_data = {push_tag, CONV_RESULT_I};
  wire push_ok = push_req && fifo_in_ready;
  // Full buffer: the result is lost, stored words untouched
  wire push_lost = push_req && !fifo_in_ready;

  // Host writes are not routed anywhere: the word has no write path
  wire host_write_ignored = WORD_WR_I;
  wire [WORD_W-1:0] host_wdata_ignored = WORD_WDATA_I;
  wire unused_host = host_write_ignored ^ (^host_wdata_ignored);

  wire pop_any = WORD_RD_I && fifo_out_valid;
  wire one_left = count_is(fifo_count, 1);
  wire at_capacity = count_is(fifo_count, DEPTH);
  // A push landing with the last pop keeps one entry, so empty stays clear
  wire last_read = pop_any && one_left && !push_ok;

  // Flags follow the buffer every cycle; the data field stands until the next read
  wire idle_full = at_capacity;
  wire idle_empty = !fifo_out_valid;
  wire read_full = 1'b0;
  wire read_empty = last_read;
  wire [FW-1:0] held_entry = {WORD_RDATA_O[TAG_BIT], WORD_RDATA_O[RES_MSB:0]};
  wire [WORD_W-1:0] word_on_read = make_word(read_full, read_empty, fifo_out_data);
  wire [WORD_W-1:0] word_on_idle = make_word(idle_full, idle_empty, held_entry);
  wire [WORD_W-1:0] word_d = pop_any ? word_on_read : word_on_idle;
  tarb_scan_seq u_seq (
    .clk_i(CLK_I),
    .rst_n_i(RESETN_I),
    .ce_i(CE_I),
    .start_i(SCAN_START_I),
    .scan_i(SCAN_KIND_I),
    .aux_sel_i(AUX_SELECT_I),
    .single_src_i(SINGLE_SRC_I),
    .busy_o(seq_busy),
    .want_o(seq_want),
    .step_i(step)
  );
  tarb_fifo #(
    .WIDTH(FW),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk_i(CLK_I),
    .rst_n_i(RESETN_I),
    .ce_i(CE_I),
    .in_valid_i(push_req),
    .in_ready_o(fifo_in_ready),
    .in_data_i(push_data),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(pop_any),
    .out_data_o(fifo_out_data),
    .full_o(),
    .count_o(fifo_count)
  );

  always_ff @(posedge CLK_I)
  begin
    if (!RESETN_I)
    begin
      WORD_RDATA_O <= `TARB_WORD_RESET;
    end
    else if (CE_I)
    begin
      WORD_RDATA_O <= word_d;
    end
  end

  always_ff @(posedge CLK_I)
  begin
    if (!RESETN_I)
    begin
      SCAN_BUSY_O <= 1'b0;
    end
    else if (CE_I)
    begin
      SCAN_BUSY_O <= seq_busy;
    end
  end

  always_ff @(posedge CLK_I)
  begin
    if (!RESETN_I)
    begin
      SCAN_WANT_O <= SRC_HORIZ;
    end
    else if (CE_I)
    begin
      SCAN_WANT_O <= seq_want;
    end
  end

  always_ff @(posedge CLK_I)
  begin
    if (!RESETN_I)
    begin
      RESULT_DROPPED_O <= 1'b0;
    end
    else if (CE_I)
    begin
      RESULT_DROPPED_O <= push_lost;
    end
  end
endmodule // tarb_result_buffer
`default_nettype wire

// [verification/tarb_asserts.sv]
`timescale 1ns/10ps
`default_nettype none
module tarb_chk
  import tarb_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RESETN_I,
  input wire logic CE_I,
  input wire logic SCAN_START_I,
  input wire tarb_scan_t SCAN_KIND_I,
  input wire logic [2:0] AUX_SELECT_I,
  input wire logic WORD_RD_I,
  input wire logic [15:0] WORD_RDATA_O,
  input wire logic SCAN_BUSY_O,
  input wire tarb_src_t SCAN_WANT_O
);
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RESETN_I);
  wire logic go = CE_I && SCAN_START_I && !SCAN_BUSY_O;
  a_reset_word: assert property ($rose(RESETN_I) |-> WORD_RDATA_O == 16'h4000)
    else $error("word not at reset image");
  a_rsvd_zero: assert property (WORD_RDATA_O[13] == 1'b0)
    else $error("reserved bit set");
  a_flags_apart: assert property (!(WORD_RDATA_O[15] && WORD_RDATA_O[14]))
    else $error("full and empty together");
  a_xy_first: assert property (go && SCAN_KIND_I == SCAN_XY |-> ##2 SCAN_WANT_O == SRC_VERT)
    else $error("xy scan not vertical first");
  a_xyz_first: assert property (go && SCAN_KIND_I == SCAN_XYZ |-> ##2 SCAN_WANT_O == SRC_VERT)
    else $error("full scan not vertical first");
  a_z_first: assert property (go && SCAN_KIND_I == SCAN_Z
    |-> ##2 SCAN_WANT_O == SRC_PRESSURE_FIRST)
    else $error("pressure scan order wrong");
  a_port_first: assert property (go && SCAN_KIND_I == SCAN_PORT
    |-> ##2 SCAN_WANT_O == SRC_BATTERY_INPUT)
    else $error("port scan not battery first");
  a_aux_first: assert property (go && SCAN_KIND_I == SCAN_AUTO_AUX && AUX_SELECT_I[0]
    |-> ##2 SCAN_WANT_O == SRC_FIRST_AUXILIARY_INPUT)
    else $error("aux scan order wrong");
  a_full_kept: assert property (CE_I && WORD_RDATA_O[15] && !WORD_RD_I |=> WORD_RDATA_O[15])
    else $error("full lost without read");
  a_busy_cause: assert property ($rose(SCAN_BUSY_O) |-> $past(go, 2))
    else $error("busy without start");
endmodule // tarb_chk
bind tarb_result_buffer tarb_chk u_tarb_chk (.*);
`default_nettype wire

// [verification/tarb_conv_model.sv]
`timescale 1ns/10ps
`default_nettype none
module tarb_conv_model (
  input wire logic clk_i,
  input wire logic busy_i,
  input wire logic slow_i,
  output logic done_o,
  output logic [11:0] res_o
);
  initial
  begin
    done_o = 1'b0;
    res_o = 12'h0;
  end
  // Gaps between results give the sequencer a cycle to step
  always @(posedge clk_i)
  begin
    done_o <= busy_i && !done_o && (!slow_i || $urandom_range(2) == 0);
    res_o <= 12'($urandom);
  end
endmodule // tarb_conv_model
`default_nettype wire

// [verification/tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import tarb_pkg::*;
;
  logic clk = 1'b0, rstn = 1'b0, mode = 1'b1, start = 1'b0, rd = 1'b0, wr = 1'b0;
  logic slow = 1'b0, busy, done, drop;
  logic exp_drop = 1'b0;
  logic [2:0] sel = 3'h1;
  logic [11:0] res;
  logic [15:0] wdata = 16'h0, rdata;
  tarb_scan_t kind = SCAN_XY;
  tarb_src_t ssrc = SRC_HORIZ, want;
  tarb_src_t exp_src[$];
  tarb_src_t aux[3] = '{SRC_FIRST_AUXILIARY_INPUT, SRC_SECOND_AUXILIARY_INPUT, SRC_TEMPERATURE};
  logic [12:0] q[$];
  int errors = 0, samples_checked = 0;
  always #2.5 clk = ~clk;
  tarb_result_buffer u_tarb_result_buffer (.CLK_I(clk), .RESETN_I(rstn), .CE_I(1'b1),
    .BUFFER_MODE_I(mode), .SCAN_START_I(start), .SCAN_KIND_I(kind), .AUX_SELECT_I(sel),
    .SINGLE_SRC_I(ssrc), .CONV_DONE_I(done), .CONV_RESULT_I(res), .WORD_RD_I(rd),
    .WORD_WR_I(wr), .WORD_WDATA_I(wdata), .WORD_RDATA_O(rdata), .SCAN_BUSY_O(busy),
    .SCAN_WANT_O(want), .RESULT_DROPPED_O(drop));
  tarb_conv_model u_tarb_conv_model (.clk_i(clk), .busy_i(busy), .slow_i(slow),
    .done_o(done), .res_o(res));
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic tag_of(input tarb_src_t s);
    return s inside {SRC_VERT, SRC_PRESSURE_SECOND, SRC_FIRST_AUXILIARY_INPUT, SRC_TEMPERATURE};
  endfunction
  always @(posedge clk)
  begin
    if (rstn)
      check("dropped", 16'(drop), 16'(exp_drop));
    exp_drop = rstn && busy && done && mode && q.size() >= 64;
    if (rstn && busy && done)
    begin
      check("source", 16'(want), 16'(exp_src[0]));
      if (mode && q.size() < 64)
        q.push_back({tag_of(exp_src[0]), res});
      void'(exp_src.pop_front());
    end
  end
  task automatic scan(input tarb_scan_t k, input logic [2:0] s, input logic sl);
    tarb_src_t f;
    f = tarb_src_t'(3'($urandom));
    case (k)
      SCAN_XY: exp_src = '{SRC_VERT, SRC_HORIZ};
      SCAN_XYZ: exp_src = '{SRC_VERT, SRC_HORIZ, SRC_PRESSURE_FIRST, SRC_PRESSURE_SECOND};
      SCAN_Z: exp_src = '{SRC_PRESSURE_FIRST, SRC_PRESSURE_SECOND};
      SCAN_PORT: exp_src = '{SRC_BATTERY_INPUT, aux[0], aux[1]};
      SCAN_AUTO_AUX:
        for (int j = 0; j < 3; j++)
          if (s[j])
            exp_src.push_back(aux[j]);
      default: exp_src = '{f};
    endcase
    @(posedge clk);
    kind <= k;
    sel <= s;
    ssrc <= f;
    slow <= sl;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    repeat (2) @(posedge clk);
    for (int n = 0; n < 99; n++)
    begin
      @(negedge clk);
      if (busy === 1'b0)
        break;
    end
    check("left", 16'(exp_src.size()), 16'h0);
  endtask
  task automatic rd_word(output logic [15:0] w);
    @(posedge clk);
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    w = rdata;
  endtask
  task automatic drain();
    logic [15:0] w;
    logic [12:0] e;
    while (q.size() > 0)
    begin
      e = q.pop_front();
      rd_word(w);
      check("word", w, {1'b0, q.size() == 0, 1'b0, e});
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    #100000;
    errors++;
    finish_test();
  end
  initial
  begin
    logic [15:0] w;
    void'($urandom(32'h6d15));
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    check("reset", rdata, 16'h4000);
    @(posedge clk);
    wr <= 1'b1;
    wdata <= 16'hbfff;
    @(posedge clk);
    wr <= 1'b0;
    @(negedge clk);
    check("write", rdata, 16'h4000);
    for (int i = 0; i < 12; i++)
    begin
      scan(tarb_scan_t'(3'(i % 6)), i < 6 ? 3'h7 : 3'($urandom_range(6, 2)), i[0]);
      drain();
      $display("scan test %0d done", i);
    end
    @(posedge clk);
    mode <= 1'b0;
    scan(SCAN_XY, 3'h1, 1'b0);
    rd_word(w);
    check("mode off", 16'(w[14]), 16'h1);
    @(posedge clk);
    mode <= 1'b1;
    repeat (65) scan(SCAN_SINGLE, 3'h1, 1'b0);
    check("full", 16'(rdata[15]), 16'h1);
    drain();
    $display("fill test done");
    finish_test();
  end
endmodule // tb_top
`default_nettype wire
